//--- shared/trace_pkg.sv
// shared constants and types for the debug trace trigger and reset logic
package trace_pkg;
   // widths
   localparam int CPU_ADDR_W = 16;
   localparam int REG_ADDR_W = 4;
   localparam int FIFO_DEPTH = 8;

   // register offsets
   localparam logic [3:0] OFS_CONTROL = 4'h0;
   localparam logic [3:0] OFS_TRIGGER = 4'h1;
   localparam logic [3:0] OFS_STATUS = 4'h2;
   localparam logic [3:0] OFS_CMP_EXT = 4'h3;
   localparam logic [3:0] OFS_CMP_HIGH = 4'h4;
   localparam logic [3:0] OFS_CMP_LOW = 4'h5;
   localparam logic [3:0] OFS_COUNT = 4'h6;
   localparam logic [3:0] OFS_FIFO_HIGH = 4'h7;
   localparam logic [3:0] OFS_FIFO_LOW = 4'h8;

   // control register fields
   localparam int BIT_UNIT_ENABLE = 7;
   localparam int BIT_ARM = 6;
   localparam int BIT_TAG = 5;
   localparam int BIT_BREAK_ENABLE = 4;

   // trigger configuration fields
   localparam int BIT_SOURCE_SELECT = 7;
   localparam int BIT_BEGIN = 6;

   // status register fields
   localparam int BIT_A_FLAG = 7;
   localparam int BIT_ACTIVE_FLAG = 0;

   // reset values of the default begin run
   localparam logic [7:0] CONTROL_RST = 8'hc0;
   localparam logic [7:0] TRIGGER_RST = 8'h40;
   localparam logic [7:0] STATUS_RST = 8'h01;
   localparam logic [7:0] CMP_EXT_RST = 8'h00;
   localparam logic [7:0] CMP_HIGH_RST = 8'hff;
   localparam logic [7:0] CMP_LOW_RST = 8'hfe;

   // a taken branch is stored as the previous address less this
   localparam logic [15:0] BRANCH_BACK = 16'h0002;

   // trace run progress
   typedef enum logic [1:0] {
      RUN_IDLE = 2'b00,
      RUN_PRE = 2'b01,
      RUN_POST = 2'b10
   } run_state_type;
endpackage : trace_pkg

//--- core/addr_match.sv
// equality comparator between a bus address and a reference
module addr_match #(
   parameter int WIDTH = 24
) (
   // compared values
   input wire logic [WIDTH-1:0] bus_addr,
   input wire logic [WIDTH-1:0] ref_addr,
   // result
   output logic hit
);
   // purely combinational, registered by the user
   always_comb begin
      hit = (bus_addr == ref_addr);
   end
endmodule : addr_match

//--- core/trace_store.sv
// eight word trace buffer, oldest word dropped when written while full
module trace_store #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8,
   parameter int CNT_W = $clog2(DEPTH + 1)
) (
   // clock
   input wire logic sys_clk,
   // control
   input wire logic clear,
   input wire logic push,
   input wire logic [WIDTH-1:0] push_data,
   input wire logic pop,
   // state
   output logic [WIDTH-1:0] head,
   output logic [CNT_W-1:0] count
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [PTR_W-1:0] rd_ptr_r, rd_ptr_nxt;
   logic [PTR_W-1:0] wr_ptr_r, wr_ptr_nxt;
   logic [CNT_W-1:0] count_r, count_nxt;
   logic full;

   ////////////////////////////////////////////////////////////////////////
   // pointer and count update; a pop never lowers the count of the run
   always_comb begin
      full = (count_r == CNT_W'(DEPTH));
      rd_ptr_nxt = rd_ptr_r;
      wr_ptr_nxt = wr_ptr_r;
      count_nxt = count_r;
      if (clear) begin
         rd_ptr_nxt = '0;
         wr_ptr_nxt = '0;
         count_nxt = '0;
      end else if (push) begin
         wr_ptr_nxt = wr_ptr_r + 1'b1;
         if (full) begin
            rd_ptr_nxt = rd_ptr_r + 1'b1; // keep the newest words
         end else begin
            count_nxt = count_r + 1'b1;
         end
      end else if (pop) begin
         rd_ptr_nxt = rd_ptr_r + 1'b1;
      end
   end

   // registers only
   always_ff @(posedge sys_clk) begin
      rd_ptr_r <= rd_ptr_nxt;
      wr_ptr_r <= wr_ptr_nxt;
      count_r <= count_nxt;
      if (push && !clear) begin
         mem_r[wr_ptr_r] <= push_data;
      end
   end

   assign head = mem_r[rd_ptr_r];
   assign count = count_r;
endmodule : trace_store

//--- core/trace_trigger.sv
// trigger resolution, trace run control and reset handling of the trace unit
// Notes on behaviour
// - opcode triggers are dropped when an interrupt pends that cycle.
// - fetch triggers still fire with a pending interrupt, ending an end run.
// - that end trigger clears arm without storing the interrupt flow change.
// - a begin trigger with a pending interrupt stores the flow change.
// - after a begin trigger stay armed, no break, until the buffer is full.
// - the unit has no way to request or cause a system reset.
// - reset after an enabled end run clears only arm, active flag, break enable.
// - any other reset, power-on too, sets up a begin run from reset vector.
// - comparator A resets to ext 0x00, high 0xff, low 0xfe.
// - control register resets to 0xc0, enabled and armed.
// - trigger configuration resets to 0x40: fetch source, begin, A only.
// - buffer holds eight words; begin run ends after eight stored.
module trace_trigger
   import trace_pkg::*;
#(
   parameter int DEPTH = trace_pkg::FIFO_DEPTH
) (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic power_on,
   // register port
   input wire logic [trace_pkg::REG_ADDR_W-1:0] reg_addr,
   input wire logic [7:0] wr_data,
   input wire logic wr_strobe,
   input wire logic rd_strobe,
   output logic [7:0] rd_data,
   // core fetch and flow signals
   input wire logic fetch_valid,
   input wire logic [trace_pkg::CPU_ADDR_W-1:0] fetch_addr,
   input wire logic opcode_top_valid,
   input wire logic [trace_pkg::CPU_ADDR_W-1:0] opcode_top_addr,
   input wire logic int_pending,
   input wire logic [1:0] cof_flags,
   input wire logic [trace_pkg::CPU_ADDR_W-1:0] core_addr,
   // results to core and host
   output logic break_request,
   output logic trace_armed
);
   import trace_pkg::*;

   localparam int CNT_W = $clog2(DEPTH + 1);

   logic [7:0] debug_control_reg_r, debug_control_reg_nxt;
   logic [7:0] trigger_config_reg_r, trigger_config_reg_nxt;
   logic [7:0] debug_status_reg_r, debug_status_reg_nxt;
   logic [7:0] comparator_a_ext_r, comparator_a_ext_nxt;
   logic [7:0] comparator_a_high_r, comparator_a_high_nxt;
   logic [7:0] comparator_a_low_r, comparator_a_low_nxt;
   run_state_type run_r, run_nxt;
   logic [CPU_ADDR_W-1:0] prev_addr_r;
   logic [7:0] rd_data_r, rd_data_nxt;
   logic break_r, break_nxt;
   logic [23:0] cmp_ref;
   logic fetch_hit, opcode_hit;
   logic fetch_trig, opcode_trig, trig;
   logic keep_results;
   logic push, clear, pop;
   logic [CPU_ADDR_W-1:0] push_data, fifo_head;
   logic [CNT_W-1:0] fifo_count;
   logic ctrl_write;

   ////////////////////////////////////////////////////////////////////////
   // comparator A; cpu addresses carry a zero extension byte
   assign cmp_ref = {comparator_a_ext_r, comparator_a_high_r, comparator_a_low_r};

   addr_match #(.WIDTH(24)) fetch_cmp (
      .bus_addr({8'h00, fetch_addr}),
      .ref_addr(cmp_ref),
      .hit(fetch_hit)
   );

   addr_match #(.WIDTH(24)) opcode_cmp (
      .bus_addr({8'h00, opcode_top_addr}),
      .ref_addr(cmp_ref),
      .hit(opcode_hit)
   );

   ////////////////////////////////////////////////////////////////////////
   // trigger sources; only the A-only match mode is decoded here
   always_comb begin
      fetch_trig = (run_r != RUN_IDLE) && debug_control_reg_r[BIT_UNIT_ENABLE]
         && !trigger_config_reg_r[BIT_SOURCE_SELECT] && fetch_valid && fetch_hit;
      // the pending interrupt takes the opcode away before it executes
      opcode_trig = (run_r != RUN_IDLE) && debug_control_reg_r[BIT_UNIT_ENABLE]
         && trigger_config_reg_r[BIT_SOURCE_SELECT] && opcode_top_valid && opcode_hit
         && !int_pending;
      trig = fetch_trig || opcode_trig;
      push_data = cof_flags[1] ? core_addr : (prev_addr_r - BRANCH_BACK);
      ctrl_write = wr_strobe && (reg_addr == OFS_CONTROL);
      // an enabled end run survives a non power-on reset
      keep_results = !power_on && debug_control_reg_r[BIT_UNIT_ENABLE]
         && !trigger_config_reg_r[BIT_BEGIN];
   end

   ////////////////////////////////////////////////////////////////////////
   // run control, register writes and reset, in rising priority
   always_comb begin
      debug_control_reg_nxt = debug_control_reg_r;
      trigger_config_reg_nxt = trigger_config_reg_r;
      debug_status_reg_nxt = debug_status_reg_r;
      comparator_a_ext_nxt = comparator_a_ext_r;
      comparator_a_high_nxt = comparator_a_high_r;
      comparator_a_low_nxt = comparator_a_low_r;
      run_nxt = run_r;
      push = 1'b0;
      clear = 1'b0;
      break_nxt = 1'b0;
      case (run_r)
         RUN_IDLE: begin
            run_nxt = RUN_IDLE;
         end
         RUN_PRE: begin
            if (!debug_control_reg_r[BIT_UNIT_ENABLE]) begin
               run_nxt = RUN_IDLE;
            end else if (trigger_config_reg_r[BIT_BEGIN]) begin
               if (trig) begin
                  run_nxt = RUN_POST;
                  debug_status_reg_nxt[BIT_A_FLAG] = 1'b1;
                  push = |cof_flags;
               end
            end else begin
               // flow change that rides on the interrupt is not kept
               push = (|cof_flags) && !(trig && int_pending);
               if (trig) begin
                  run_nxt = RUN_IDLE;
                  debug_status_reg_nxt[BIT_A_FLAG] = 1'b1;
                  break_nxt = debug_control_reg_r[BIT_BREAK_ENABLE];
               end
            end
         end
         RUN_POST: begin
            push = |cof_flags;
            // stays armed, and silent, until the last word lands
            if (push && (fifo_count == CNT_W'(DEPTH - 1))) begin
               run_nxt = RUN_IDLE;
               break_nxt = debug_control_reg_r[BIT_BREAK_ENABLE];
            end
         end
         default: begin
            run_nxt = RUN_IDLE;
         end
      endcase
      if (wr_strobe) begin
         case (reg_addr)
            OFS_CONTROL: begin
               debug_control_reg_nxt = wr_data;
               if (wr_data[BIT_ARM] && wr_data[BIT_UNIT_ENABLE]) begin
                  run_nxt = RUN_PRE;
                  clear = 1'b1;
                  push = 1'b0;
                  debug_status_reg_nxt[BIT_A_FLAG] = 1'b0;
               end else begin
                  run_nxt = RUN_IDLE;
               end
               break_nxt = 1'b0;
            end
            OFS_TRIGGER: trigger_config_reg_nxt = wr_data;
            OFS_CMP_EXT: comparator_a_ext_nxt = wr_data;
            OFS_CMP_HIGH: comparator_a_high_nxt = wr_data;
            OFS_CMP_LOW: comparator_a_low_nxt = wr_data;
            default: begin
               run_nxt = run_nxt;
            end
         endcase
      end
      if (rst) begin
         push = 1'b0;
         break_nxt = 1'b0;
         run_nxt = RUN_IDLE;
         if (keep_results) begin
            debug_control_reg_nxt[BIT_BREAK_ENABLE] = 1'b0;
         end else begin
            // power-on and plain resets restart a begin run at the vector
            run_nxt = RUN_PRE;
            clear = 1'b1;
            debug_control_reg_nxt = CONTROL_RST;
            trigger_config_reg_nxt = TRIGGER_RST;
            debug_status_reg_nxt = STATUS_RST;
            comparator_a_ext_nxt = CMP_EXT_RST;
            comparator_a_high_nxt = CMP_HIGH_RST;
            comparator_a_low_nxt = CMP_LOW_RST;
         end
      end
      // arm bit and active flag always follow the run state
      debug_control_reg_nxt[BIT_ARM] = (run_nxt != RUN_IDLE);
      debug_status_reg_nxt[BIT_ACTIVE_FLAG] = (run_nxt != RUN_IDLE);
   end

   ////////////////////////////////////////////////////////////////////////
   // read mux; the buffer only advances while the unit is disarmed
   always_comb begin
      pop = rd_strobe && (reg_addr == OFS_FIFO_LOW) && (run_r == RUN_IDLE) && !rst;
      rd_data_nxt = 8'h00;
      if (rd_strobe) begin
         case (reg_addr)
            OFS_CONTROL: rd_data_nxt = debug_control_reg_r;
            OFS_TRIGGER: rd_data_nxt = trigger_config_reg_r;
            OFS_STATUS: rd_data_nxt = debug_status_reg_r;
            OFS_CMP_EXT: rd_data_nxt = comparator_a_ext_r;
            OFS_CMP_HIGH: rd_data_nxt = comparator_a_high_r;
            OFS_CMP_LOW: rd_data_nxt = comparator_a_low_r;
            OFS_COUNT: rd_data_nxt = 8'(fifo_count);
            OFS_FIFO_HIGH: rd_data_nxt = fifo_head[15:8];
            OFS_FIFO_LOW: rd_data_nxt = fifo_head[7:0];
            default: rd_data_nxt = 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // state registers; reset is folded into the next-state logic above
   always_ff @(posedge sys_clk) begin
      debug_control_reg_r <= debug_control_reg_nxt;
      trigger_config_reg_r <= trigger_config_reg_nxt;
      debug_status_reg_r <= debug_status_reg_nxt;
      comparator_a_ext_r <= comparator_a_ext_nxt;
      comparator_a_high_r <= comparator_a_high_nxt;
      comparator_a_low_r <= comparator_a_low_nxt;
      run_r <= run_nxt;
      prev_addr_r <= core_addr;
      rd_data_r <= rd_data_nxt;
      break_r <= break_nxt;
   end

   trace_store #(.WIDTH(CPU_ADDR_W), .DEPTH(DEPTH), .CNT_W(CNT_W)) store (
      .sys_clk(sys_clk),
      .clear(clear),
      .push(push),
      .push_data(push_data),
      .pop(pop),
      .head(fifo_head),
      .count(fifo_count)
   );

   // outputs straight from flops; no reset request output exists at all
   assign rd_data = rd_data_r;
   assign break_request = break_r;
   assign trace_armed = debug_status_reg_r[BIT_ACTIVE_FLAG];

   ////////////////////////////////////////////////////////////////////////
   // checks
   opcode_irq_drop_a: assert property (@(posedge sys_clk) disable iff (rst)
      (opcode_trig == 1'b0 && trigger_config_reg_r[BIT_SOURCE_SELECT] && opcode_top_valid
       && opcode_hit && int_pending && run_r == RUN_PRE && !wr_strobe
       && !debug_status_reg_r[BIT_A_FLAG])
      |=> !debug_status_reg_r[BIT_A_FLAG] && run_r == RUN_PRE)
      else $error("opcode trigger taken despite pending interrupt");

   end_irq_trigger_a: assert property (@(posedge sys_clk) disable iff (rst)
      (run_r == RUN_PRE && !trigger_config_reg_r[BIT_BEGIN] && fetch_trig && int_pending
       && !wr_strobe)
      |=> run_r == RUN_IDLE && !debug_control_reg_r[BIT_ARM]
          && break_request == $past(debug_control_reg_r[BIT_BREAK_ENABLE]))
      else $error("end trigger missed with pending interrupt");

   end_irq_nostore_a: assert property (@(posedge sys_clk) disable iff (rst)
      (run_r == RUN_PRE && !trigger_config_reg_r[BIT_BEGIN] && fetch_trig && int_pending
       && !wr_strobe)
      |=> $stable(fifo_count) ##1 $stable(fifo_count))
      else $error("interrupt flow change stored after end trigger");

   begin_irq_store_a: assert property (@(posedge sys_clk) disable iff (rst)
      (run_r == RUN_PRE && trigger_config_reg_r[BIT_BEGIN] && fetch_trig && int_pending
       && (|cof_flags) && !wr_strobe && fifo_count == '0)
      |=> run_r == RUN_POST && fifo_count == CNT_W'(1) && fifo_head == $past(push_data))
      else $error("begin trigger flow change not captured");

   begin_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      (run_r == RUN_POST && fifo_count < CNT_W'(DEPTH - 1) && !ctrl_write)
      |=> run_r != RUN_IDLE && !break_request && trace_armed)
      else $error("begin run ended before buffer full");

   end_reset_keep_a: assert property (@(posedge sys_clk)
      (rst && keep_results)
      |=> !debug_control_reg_r[BIT_ARM] && !debug_control_reg_r[BIT_BREAK_ENABLE]
          && !debug_status_reg_r[BIT_ACTIVE_FLAG]
          && trigger_config_reg_r == $past(trigger_config_reg_r)
          && cmp_ref == $past(cmp_ref) && fifo_count == $past(fifo_count))
      else $error("end run results not kept over reset");

   vector_begin_a: assert property (@(posedge sys_clk)
      (rst && !keep_results) ##1 (!rst && !wr_strobe && fetch_valid
       && fetch_addr == 16'hfffe)
      |=> run_r == RUN_POST && debug_status_reg_r[BIT_A_FLAG])
      else $error("default run did not start at vector fetch");

   cmp_reset_a: assert property (@(posedge sys_clk)
      (rst && !keep_results)
      |=> comparator_a_ext_r == 8'h00 && comparator_a_high_r == 8'hff
          && comparator_a_low_r == 8'hfe)
      else $error("comparator A reset value wrong");

   control_reset_a: assert property (@(posedge sys_clk)
      (rst && !keep_results) |=> debug_control_reg_r == 8'hc0 && trace_armed)
      else $error("control register reset value wrong");

   trigger_reset_a: assert property (@(posedge sys_clk)
      (rst && !keep_results) |=> trigger_config_reg_r == 8'h40 && fifo_count == '0)
      else $error("trigger configuration reset value wrong");

   fill_stop_a: assert property (@(posedge sys_clk) disable iff (rst)
      (run_r == RUN_POST && push && fifo_count == CNT_W'(DEPTH - 1) && !ctrl_write)
      |=> run_r == RUN_IDLE && fifo_count == CNT_W'(DEPTH)
          && break_request == $past(debug_control_reg_r[BIT_BREAK_ENABLE]))
      else $error("begin run did not end at eight words");

   end_collision_c: cover property (@(posedge sys_clk) disable iff (rst)
      run_r == RUN_PRE && !trigger_config_reg_r[BIT_BEGIN] && fetch_trig && int_pending);
   begin_collision_c: cover property (@(posedge sys_clk) disable iff (rst)
      run_r == RUN_PRE && trigger_config_reg_r[BIT_BEGIN] && fetch_trig && int_pending);
   begin_full_c: cover property (@(posedge sys_clk) disable iff (rst)
      run_r == RUN_POST ##1 run_r == RUN_IDLE);
   reset_keep_c: cover property (@(posedge sys_clk) rst && keep_results);
endmodule : trace_trigger

//--- tb/core_model.sv
// behavioural model of the core fetch pipeline and change of flow signals
module core_model (
   // clock
   input wire logic sys_clk,
   // fetch and flow signals towards the trace unit
   output logic fetch_valid,
   output logic [15:0] fetch_addr,
   output logic opcode_top_valid,
   output logic [15:0] opcode_top_addr,
   output logic int_pending,
   output logic [1:0] cof_flags,
   output logic [15:0] core_addr
);
   timeunit 1ns;
   timeprecision 100ps;

   // quiet pipe at time zero
   initial begin
      fetch_valid = 1'b0;
      fetch_addr = 16'h0000;
      opcode_top_valid = 1'b0;
      opcode_top_addr = 16'h0000;
      int_pending = 1'b0;
      cof_flags = 2'b00;
      core_addr = 16'h0000;
   end

   // one pipe cycle; an address without its valid toggles so it is never stale
   task automatic step(input logic fv, input logic [15:0] fa, input logic ov,
      input logic [15:0] oa, input logic ip, input logic [1:0] cof, input logic [15:0] ca);
      @(posedge sys_clk);
      fetch_valid <= fv;
      fetch_addr <= fv ? fa : ~fetch_addr;
      opcode_top_valid <= ov;
      opcode_top_addr <= ov ? oa : ~opcode_top_addr;
      int_pending <= ip;
      cof_flags <= cof;
      core_addr <= ca;
      #1;
   endtask : step
endmodule : core_model

//--- tb/trace_trigger_tb_top.sv
// self-checking bench of the trace trigger and reset logic
module trace_trigger_tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import trace_pkg::*;

   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic power_on = 1'b1;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] wr_data = 8'h00;
   logic wr_strobe = 1'b0;
   logic rd_strobe = 1'b0;
   logic [7:0] rd_data;
   logic fetch_valid, opcode_top_valid, int_pending, break_request, trace_armed;
   logic [15:0] fetch_addr, opcode_top_addr, core_addr, prev_ca, t;
   logic [1:0] cof_flags;
   logic [15:0] exp_q[$];
   int seed = 8738;
   int error_cnt = 0;
   int check_count = 0;

   // 250 MHz clock
   always #2 sys_clk = ~sys_clk;

   trace_trigger trace_trigger_i (.sys_clk(sys_clk), .rst(rst), .power_on(power_on),
      .reg_addr(reg_addr), .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
      .rd_data(rd_data), .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
      .opcode_top_valid(opcode_top_valid), .opcode_top_addr(opcode_top_addr),
      .int_pending(int_pending), .cof_flags(cof_flags), .core_addr(core_addr),
      .break_request(break_request), .trace_armed(trace_armed));

   core_model core_model_i (.sys_clk(sys_clk), .fetch_valid(fetch_valid),
      .fetch_addr(fetch_addr), .opcode_top_valid(opcode_top_valid),
      .opcode_top_addr(opcode_top_addr), .int_pending(int_pending),
      .cof_flags(cof_flags), .core_addr(core_addr));

   ////////////////////////////////////////////////////////////////////////////
   // expectation helpers
   function automatic logic [15:0] exp_word(input logic [1:0] cof, input logic [15:0] ca,
      input logic [15:0] prev);
      return cof[1] ? ca : prev - BRANCH_BACK;
   endfunction : exp_word

   function automatic logic [15:0] rnd16();
      return 16'($random(seed));
   endfunction : rnd16

   function automatic logic [1:0] rcof();
      return ($random(seed) & 1) ? 2'b01 : 2'b10;
   endfunction : rcof

   task automatic conclude();
      if (error_cnt == 0 && check_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : conclude

   task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask : chk

   ////////////////////////////////////////////////////////////////////////////
   // register port and pipe drivers
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      wr_data <= d;
      wr_strobe <= 1'b1;
      @(posedge sys_clk);
      wr_strobe <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      reg_addr <= a;
      rd_strobe <= 1'b1;
      @(posedge sys_clk);
      rd_strobe <= 1'b0;
      #1;
      d = rd_data;
   endtask : rd

   // one pipe cycle, recording any word the unit should store
   task automatic cyc(input logic fv, input logic [15:0] fa, input logic ov, input logic ip,
      input logic [1:0] cof, input logic [15:0] ca);
      if (cof != 2'b00) exp_q.push_back(exp_word(cof, ca, prev_ca));
      core_model_i.step(fv, fa, ov, fa, ip, cof, ca);
      prev_ca = ca;
   endtask : cyc

   // bounded wait for a break pulse or for the run to drop
   task automatic wait_for(input bit brk);
      for (int i = 0; i < 6; i++) begin
         cyc(1'b0, 16'h0000, 1'b0, 1'b0, 2'b00, prev_ca);
         if (brk ? break_request === 1'b1 : trace_armed === 1'b0) return;
      end
      error_cnt++;
      $display("MISMATCH wait expected %h seen timeout", brk);
      conclude();
   endtask : wait_for

   task automatic rst_pulse(input logic p);
      @(posedge sys_clk);
      rst <= 1'b1;
      power_on <= p;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      power_on <= 1'b0;
   endtask : rst_pulse

   // drain n words through high then low byte, oldest first
   task automatic drain(input int n);
      logic [7:0] h, l;
      for (int i = 0; i < n; i++) begin
         rd(OFS_FIFO_HIGH, h);
         rd(OFS_FIFO_LOW, l);
         chk("buffer word", exp_q.pop_front(), {h, l});
      end
   endtask : drain

   task automatic chk_defaults();
      logic [7:0] d;
      logic [7:0] tbl[6] = '{CONTROL_RST, TRIGGER_RST, STATUS_RST, CMP_EXT_RST, CMP_HIGH_RST,
         CMP_LOW_RST};
      for (int i = 0; i < 6; i++) begin
         rd(4'(i), d);
         chk("default reg", tbl[i], d);
      end
      rd(4'h9, d);
      chk("unmapped", 8'h00, d);
      rd(OFS_COUNT, d);
      chk("count", 8'h00, d);
      chk("armed", 1'b1, trace_armed);
   endtask : chk_defaults

   ////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      logic [7:0] d;
      prev_ca = 16'h0000;
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      power_on <= 1'b0;
      chk_defaults();
      // default begin run from the reset vector, interrupt pending on the trigger
      wr(OFS_CONTROL, 8'hd0);
      exp_q.delete();
      cyc(1'b1, 16'hfffe, 1'b0, 1'b1, 2'b10, rnd16());
      for (int i = 0; i < 7; i++) begin
         chk("armed", 1'b1, trace_armed);
         chk("early break", 1'b0, break_request);
         cyc(1'b0, rnd16(), 1'b0, 1'($random(seed)), rcof(), rnd16());
      end
      wait_for(1'b1);
      chk("armed", 1'b0, trace_armed);
      rd(OFS_COUNT, d);
      chk("count", 8'(FIFO_DEPTH), d);
      drain(FIFO_DEPTH);
      // end run on a fetch trigger that collides with an interrupt
      t = rnd16();
      wr(OFS_CMP_EXT, 8'h00);
      wr(OFS_CMP_HIGH, t[15:8]);
      wr(OFS_CMP_LOW, t[7:0]);
      wr(OFS_TRIGGER, 8'h00);
      wr(OFS_CONTROL, 8'hd0);
      exp_q.delete();
      repeat (3) cyc(1'b0, 16'h0000, 1'b0, 1'b0, rcof(), rnd16());
      cyc(1'b1, t, 1'b0, 1'b1, 2'b10, rnd16());
      void'(exp_q.pop_back());
      wait_for(1'b1);
      chk("armed", 1'b0, trace_armed);
      rd(OFS_COUNT, d);
      chk("count", 8'h03, d);
      // reset after an enabled end run keeps the results
      rst_pulse(1'b0);
      rd(OFS_CONTROL, d);
      chk("control", 8'h80, d);
      rd(OFS_TRIGGER, d);
      chk("trigger", 8'h00, d);
      rd(OFS_STATUS, d);
      chk("active flag", 1'b0, d[BIT_ACTIVE_FLAG]);
      rd(OFS_CMP_HIGH, d);
      chk("cmp high", t[15:8], d);
      rd(OFS_COUNT, d);
      chk("count", 8'h03, d);
      chk("armed", 1'b0, trace_armed);
      drain(3);
      // opcode trigger loses to a pending interrupt, then fires without one
      wr(OFS_TRIGGER, 8'h80);
      wr(OFS_CONTROL, 8'hc0);
      cyc(1'b0, t, 1'b1, 1'b1, 2'b00, prev_ca);
      repeat (2) cyc(1'b0, 16'h0000, 1'b0, 1'b0, 2'b00, prev_ca);
      chk("armed", 1'b1, trace_armed);
      cyc(1'b0, t, 1'b1, 1'b0, 2'b00, prev_ca);
      wait_for(1'b0);
      // any other reset sets up the default begin run again
      wr(OFS_TRIGGER, 8'h40);
      rst_pulse(1'b0);
      chk_defaults();
      // power-on beats an enabled end run; the vector fetch right after release starts the run
      wr(OFS_TRIGGER, 8'h00);
      fork
         rst_pulse(1'b1);
         begin
            repeat (2) @(posedge sys_clk);
            cyc(1'b1, 16'hfffe, 1'b0, 1'b0, 2'b00, prev_ca);
         end
      join
      // take the fetch away again so it cannot stand over later cycles
      cyc(1'b0, 16'h0000, 1'b0, 1'b0, 2'b00, prev_ca);
      rd(OFS_STATUS, d);
      chk("vector status", 8'h81, d);
      rd(OFS_TRIGGER, d);
      chk("trigger", TRIGGER_RST, d);
      conclude();
   end
endmodule : trace_trigger_tb_top
